// *** rtl/amlr_regs.sv ***
// alert masks, channel limits, client config and alert pin drive
// Function
// - mask3 bit0 blocks client zero alert
// - mask3 bit1 blocks data error alert
// - mask3 bit2 blocks link error alert
// - mask3 bit3 blocks overtemp pin alert
// - mask3 bit7 blocks summary out-of-limit alert
// - summary mask independent of mask4 bits
// - mask4 bits 3-5 block clients one-three
// - mask4 bits 6,7 block current, voltage
// - both masks reset to zero
// - limits reset low 00, high ff
// - lock makes limits and config read-only
// - cpu count enables clients cumulatively
// - domain bits mark cpus dual domain
// - client config resets to zero
// - status sets on violation, read clears
module amlr_regs (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic lock,
  input wire logic [3:0] client_ool,
  input wire logic data_err,
  input wire logic link_err,
  input wire logic overtemp_evt,
  input wire logic [7:0] term_voltage_value,
  input wire logic [7:0] current_monitor_value,
  input wire logic alert_in,
  output logic alert_out,
  output logic alert_oe_n,
  output logic [1:0] cpu_count,
  output logic cpu2_dual_domain,
  output logic cpu3_dual_domain,
  output logic cpu4_dual_domain
);

  typedef struct packed {
    logic [7:0] mask3;
    logic [7:0] mask4;
    logic [7:0] tv_low;
    logic [7:0] cm_low;
    logic [7:0] tv_high;
    logic [7:0] cm_high;
    logic [7:0] client_cfg;
    logic [7:0] status4;
    logic [7:0] rdata;
    logic alert_drv;
  } amlr_state_t;

  amlr_state_t st_q;
  amlr_state_t st_d;
  logic [7:0] cond4;
  logic [3:0] src3;
  logic [3:0] unm3;
  logic s4_live;
  logic s4_any;
  logic s4_path;
  logic [3:0] quiet3;
  logic status_rd;
  logic wr_open;

  // true when a reading lies outside its window
  function automatic logic out_of_window(input logic [7:0] val, input logic [7:0] lo, input logic [7:0] hi);
    out_of_window = (val < lo) || (val > hi);
  endfunction

  // client k is polled when cpu count reaches k
  function automatic logic client_polled(input logic [1:0] count, input logic [1:0] idx);
    client_polled = (count >= idx);
  endfunction

  // alert_in is the sensed wire level; unused by this slice on purpose
  logic unused_alert_in;
  assign unused_alert_in = alert_in;

  // live condition vector for status four
  always_comb begin
    cond4 = 8'h00;
    cond4[amlr_pkg::S4_CLIENT_ONE] = client_ool[1] && client_polled(st_q.client_cfg[1:0], 2'h1);
    cond4[amlr_pkg::S4_CLIENT_TWO] = client_ool[2] && client_polled(st_q.client_cfg[1:0], 2'h2);
    cond4[amlr_pkg::S4_CLIENT_THREE] = client_ool[3] && client_polled(st_q.client_cfg[1:0], 2'h3);
    cond4[amlr_pkg::S4_CURRENT_MON] = out_of_window(current_monitor_value, st_q.cm_low, st_q.cm_high);
    cond4[amlr_pkg::S4_TERM_VOLTAGE] = out_of_window(term_voltage_value, st_q.tv_low, st_q.tv_high);
  end

  // alert sources and their masks
  always_comb begin
    src3 = {overtemp_evt, link_err, data_err, client_ool[0]};
    unm3 = src3 & ~st_q.mask3[3:0];
    s4_live = |(st_q.status4 & ~st_q.mask4 & amlr_pkg::S4_LIVE_BITS);
    // summary bit seen through mask three bit 7
    // summary bit ignores mask four, so software must set both to go quiet
    s4_any = |(st_q.status4 & amlr_pkg::S4_LIVE_BITS);
    // either path alone raises the alert
    s4_path = s4_live || (s4_any && !st_q.mask3[amlr_pkg::M3_OOL_SUMMARY]);
    for (int k = 0; k < 4; k++) begin
      quiet3[k] = ((unm3 & ~(4'h1 << k)) == 4'h0) && !s4_path;
    end
  end

  assign status_rd = reg_rd && (reg_addr == amlr_pkg::STATUS_FOUR_ADDR);
  // lock shuts limit and config writes
  assign wr_open = reg_wr && !lock;

  // next state
  always_comb begin
    st_d = st_q;
    // mask registers stay writable under lock
    if (reg_wr && reg_addr == amlr_pkg::MASK_THREE_ADDR) begin
      st_d.mask3 = reg_wdata;
    end
    if (reg_wr && reg_addr == amlr_pkg::MASK_FOUR_ADDR) begin
      st_d.mask4 = reg_wdata;
    end
    if (wr_open) begin
      case (reg_addr)
        amlr_pkg::TV_LOW_ADDR: begin
          st_d.tv_low = reg_wdata;
        end
        amlr_pkg::CM_LOW_ADDR: begin
          st_d.cm_low = reg_wdata;
        end
        amlr_pkg::TV_HIGH_ADDR: begin
          st_d.tv_high = reg_wdata;
        end
        amlr_pkg::CM_HIGH_ADDR: begin
          st_d.cm_high = reg_wdata;
        end
        amlr_pkg::CLIENT_CFG_ADDR: begin
          st_d.client_cfg = reg_wdata;
        end
        default: begin
          st_d.client_cfg = st_q.client_cfg;
        end
      endcase
    end
    // read clears only subsided bits; a new violation wins
    st_d.status4 = (status_rd ? 8'h00 : st_q.status4) | cond4;
    // read data, unmapped offsets read zero
    if (reg_rd) begin
      case (reg_addr)
        amlr_pkg::STATUS_FOUR_ADDR: begin
          st_d.rdata = st_q.status4;
        end
        amlr_pkg::MASK_THREE_ADDR: begin
          st_d.rdata = st_q.mask3;
        end
        amlr_pkg::MASK_FOUR_ADDR: begin
          st_d.rdata = st_q.mask4;
        end
        amlr_pkg::TV_LOW_ADDR: begin
          st_d.rdata = st_q.tv_low;
        end
        amlr_pkg::CM_LOW_ADDR: begin
          st_d.rdata = st_q.cm_low;
        end
        amlr_pkg::TV_HIGH_ADDR: begin
          st_d.rdata = st_q.tv_high;
        end
        amlr_pkg::CM_HIGH_ADDR: begin
          st_d.rdata = st_q.cm_high;
        end
        amlr_pkg::CLIENT_CFG_ADDR: begin
          st_d.rdata = st_q.client_cfg;
        end
        default: begin
          st_d.rdata = 8'h00;
        end
      endcase
    end
    // summary mask gates only the summary half of the status four path
    st_d.alert_drv = (|unm3) || s4_path;
  end

  // state register
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_q.mask3 <= amlr_pkg::MASK_RESET;
      st_q.mask4 <= amlr_pkg::MASK_RESET;
      st_q.tv_low <= amlr_pkg::LOW_LIMIT_RESET;
      st_q.cm_low <= amlr_pkg::LOW_LIMIT_RESET;
      st_q.tv_high <= amlr_pkg::HIGH_LIMIT_RESET;
      st_q.cm_high <= amlr_pkg::HIGH_LIMIT_RESET;
      st_q.client_cfg <= amlr_pkg::CLIENT_CFG_RESET;
      st_q.status4 <= amlr_pkg::STATUS_RESET;
      st_q.rdata <= 8'h00;
      st_q.alert_drv <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // open-drain pin: level constant, enable low while pulling
  logic alert_lvl_q;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      alert_lvl_q <= 1'b0;
    end else begin
      alert_lvl_q <= amlr_pkg::ALERT_DRIVE_LEVEL;
    end
  end

  // outputs straight from flops
  assign reg_rdata = st_q.rdata;
  assign alert_out = alert_lvl_q;
  assign alert_oe_n = !st_q.alert_drv;
  assign cpu_count = st_q.client_cfg[amlr_pkg::CFG_CPU_COUNT_LSB +: 2];
  assign cpu2_dual_domain = st_q.client_cfg[amlr_pkg::CFG_CPU2_DUAL];
  assign cpu3_dual_domain = st_q.client_cfg[amlr_pkg::CFG_CPU3_DUAL];
  assign cpu4_dual_domain = st_q.client_cfg[amlr_pkg::CFG_CPU4_DUAL];

  // first cycle after reset release, for reset-value checks
  logic seen_q;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      seen_q <= 1'b0;
    end else begin
      seen_q <= 1'b1;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  // masked sources alone keep the pin released
  a_client0_masked: assert property (st_q.mask3[0] && quiet3[0] |=> alert_oe_n)
    else $error("client zero alert not masked");
  a_data_masked: assert property (st_q.mask3[1] && quiet3[1] |=> alert_oe_n)
    else $error("data error alert not masked");
  a_link_masked: assert property (st_q.mask3[2] && quiet3[2] |=> alert_oe_n)
    else $error("link error alert not masked");
  a_overtemp_masked: assert property (st_q.mask3[3] && quiet3[3] |=> alert_oe_n)
    else $error("overtemp alert not masked");
  a_summary_masked: assert property (st_q.mask3[7] && unm3 == 4'h0 && !s4_live |=> alert_oe_n)
    else $error("summary mask did not block alert");
  a_mask4_gates: assert property (st_q.mask3[7] && unm3 == 4'h0 && st_q.status4[7:6] == 2'h0 &&
    (st_q.status4 & ~st_q.mask4 & 8'h38) == 8'h00 |=> alert_oe_n)
    else $error("mask four did not block alert");
  a_alert_fires: assert property (!st_q.mask3[7] && s4_any |=> !alert_oe_n)
    else $error("unmasked status four did not alert");

  // individual path alerts even with the summary masked
  a_ind_fires: assert property (s4_live |=> !alert_oe_n)
    else $error("individual status path did not alert");
  // voltage mask with summary mask keeps pin released
  a_mask_volt: assert property (st_q.mask3[7] && unm3 == 4'h0 && st_q.status4 == 8'h80 &&
    st_q.mask4[7] |=> alert_oe_n)
    else $error("voltage mask did not block alert");
  // current mask with summary mask keeps pin released
  a_mask_curr: assert property (st_q.mask3[7] && unm3 == 4'h0 && st_q.status4 == 8'h40 &&
    st_q.mask4[6] |=> alert_oe_n)
    else $error("current mask did not block alert");
  // nothing but the two decoded paths drives the pin
  a_reserved_quiet: assert property (unm3 == 4'h0 && !s4_path |=> alert_oe_n)
    else $error("alert from reserved or masked source");
  // reserved status bits never set
  a_status_rsvd: assert property (st_q.status4[2:0] == 3'h0)
    else $error("reserved status bit set");

  // each live mask three source raises the pin when unmasked
  a_client0_src: assert property (client_ool[0] && !st_q.mask3[0] |=> !alert_oe_n)
    else $error("client zero did not alert");
  a_data_src: assert property (data_err && !st_q.mask3[1] |=> !alert_oe_n)
    else $error("data error did not alert");
  a_link_src: assert property (link_err && !st_q.mask3[2] |=> !alert_oe_n)
    else $error("link error did not alert");
  a_overtemp_src: assert property (overtemp_evt && !st_q.mask3[3] |=> !alert_oe_n)
    else $error("overtemp did not alert");
  a_source_fires: assert property (unm3 != 4'h0 |=> !alert_oe_n)
    else $error("unmasked source did not alert");
  a_reset_values: assert property (!seen_q |-> st_q.mask3 == 8'h00 && st_q.mask4 == 8'h00 &&
    st_q.tv_low == 8'h00 && st_q.cm_high == 8'hff && st_q.client_cfg == 8'h00)
    else $error("wrong value after reset");
  a_lock_holds: assert property (lock && reg_wr |=> $stable(st_q.tv_low) && $stable(st_q.tv_high) &&
    $stable(st_q.cm_low) && $stable(st_q.cm_high) && $stable(st_q.client_cfg))
    else $error("locked register changed");
  a_status_read: assert property (status_rd |=> st_q.status4 == $past(cond4))
    else $error("status read clear wrong");
  a_status_sticky: assert property (!status_rd && st_q.status4[6] |=> st_q.status4[6])
    else $error("status bit dropped without read");
  a_one_cpu: assert property (cpu_count == 2'h0 |-> cond4[5:3] == 3'h0)
    else $error("unpolled client set status");
  a_two_cpus: assert property (cpu_count == 2'h1 |-> cond4[5:4] == 2'h0)
    else $error("unpolled client two or three set status");

  // a violation always lands in status, read or not
  a_status_sets: assert property (cond4 != 8'h00 |=> (st_q.status4 & $past(cond4)) == $past(cond4))
    else $error("violation not captured");
  // status read returns the value before the clear
  a_status_rdata: assert property (status_rd |=> reg_rdata == $past(st_q.status4))
    else $error("status read data wrong");

  // open limit writes land, reads return them
  a_limit_write: assert property (wr_open && reg_addr == amlr_pkg::TV_HIGH_ADDR |=>
    st_q.tv_high == $past(reg_wdata))
    else $error("limit write lost");
  a_limit_read: assert property (reg_rd && reg_addr == amlr_pkg::CM_LOW_ADDR |=>
    reg_rdata == $past(st_q.cm_low))
    else $error("limit read data wrong");
  // masks keep taking writes under lock
  a_lock_masks: assert property (lock && reg_wr && reg_addr == amlr_pkg::MASK_THREE_ADDR |=>
    st_q.mask3 == $past(reg_wdata))
    else $error("mask write blocked by lock");
  // reserved mask bits stored as written
  a_mask_store: assert property (reg_wr && reg_addr == amlr_pkg::MASK_FOUR_ADDR |=>
    st_q.mask4 == $past(reg_wdata))
    else $error("mask four write lost");

  // config field lands on its output pins
  a_cfg_count: assert property (wr_open && reg_addr == amlr_pkg::CLIENT_CFG_ADDR |=>
    cpu_count == $past(reg_wdata[1:0]))
    else $error("cpu count not taken");
  a_cfg_domain: assert property (wr_open && reg_addr == amlr_pkg::CLIENT_CFG_ADDR |=>
    {cpu4_dual_domain, cpu3_dual_domain, cpu2_dual_domain} == $past(reg_wdata[4:2]))
    else $error("domain bits not taken");
  a_cfg_reset: assert property (!seen_q |-> cpu_count == 2'h0 && !cpu2_dual_domain &&
    !cpu3_dual_domain && !cpu4_dual_domain)
    else $error("config outputs wrong after reset");

  c_alert_raised: cover property (st_q.alert_drv ##1 !st_q.alert_drv);
  c_locked_write: cover property (lock && reg_wr && reg_addr == amlr_pkg::TV_HIGH_ADDR);
  c_status_clear: cover property (status_rd && st_q.status4 != 8'h00 && cond4 == 8'h00);
  c_four_cpus: cover property (cpu_count == 2'h3 && client_ool[3]);
  c_both_needed: cover property (st_q.mask3[7] && s4_any && !s4_live);

endmodule

// *** rtl/amlr_pkg.sv ***
// constants for the alert mask and limit register slice
package amlr_pkg;
  // register offsets
  localparam logic [7:0] STATUS_FOUR_ADDR = 8'h81;
  localparam logic [7:0] MASK_THREE_ADDR = 8'h82;
  localparam logic [7:0] MASK_FOUR_ADDR = 8'h83;
  localparam logic [7:0] TV_LOW_ADDR = 8'h84;
  localparam logic [7:0] CM_LOW_ADDR = 8'h85;
  localparam logic [7:0] TV_HIGH_ADDR = 8'h86;
  localparam logic [7:0] CM_HIGH_ADDR = 8'h87;
  localparam logic [7:0] CLIENT_CFG_ADDR = 8'h88;
  // reset values
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] LOW_LIMIT_RESET = 8'h00;
  localparam logic [7:0] HIGH_LIMIT_RESET = 8'hff;
  localparam logic [7:0] CLIENT_CFG_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // mask three fields
  localparam int M3_CLIENT_ZERO = 0;
  localparam int M3_DATA_ERR = 1;
  localparam int M3_LINK_ERR = 2;
  localparam int M3_OVERTEMP = 3;
  localparam int M3_OOL_SUMMARY = 7;
  // mask four and status four fields
  localparam int S4_CLIENT_ONE = 3;
  localparam int S4_CLIENT_TWO = 4;
  localparam int S4_CLIENT_THREE = 5;
  localparam int S4_CURRENT_MON = 6;
  localparam int S4_TERM_VOLTAGE = 7;
  localparam logic [7:0] S4_LIVE_BITS = 8'hf8;
  // client configuration fields
  localparam int CFG_CPU_COUNT_LSB = 0;
  localparam int CFG_CPU2_DUAL = 2;
  localparam int CFG_CPU3_DUAL = 3;
  localparam int CFG_CPU4_DUAL = 4;
  // alert pin drive level while asserted
  localparam logic ALERT_DRIVE_LEVEL = 1'b0;
endpackage

// *** tb/amlr_host.sv ***
// host side model of the shared alert wire
module amlr_host (
  input wire logic alert_out,
  input wire logic alert_oe_n,
  output logic alert_wire
);
  timeunit 1ns;
  timeprecision 1ns;
  // pull-up holds the wire high when released
  assign alert_wire = alert_oe_n ? 1'b1 : alert_out;
endmodule

// *** tb/tb.sv ***
// self-checking bench for the alert mask and limit registers
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic lock = 1'b0;
  logic [3:0] client_ool = 4'h0;
  logic data_err = 1'b0;
  logic link_err = 1'b0;
  logic overtemp_evt = 1'b0;
  logic [7:0] tv = 8'h40;
  logic [7:0] cm = 8'h40;
  logic [7:0] reg_rdata, v, m3;
  logic [3:0] src;
  logic alert_wire, alert_out, alert_oe_n;
  logic [1:0] cpu_count;
  logic cpu2_dual_domain, cpu3_dual_domain, cpu4_dual_domain;
  logic [7:0] addrs [8] = '{8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h87, 8'h88, 8'h90};
  logic [7:0] rsts [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00};
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;

  always #5 mclk = ~mclk;

  amlr_regs amlr_regs_i (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .lock(lock),
    .client_ool(client_ool), .data_err(data_err), .link_err(link_err),
    .overtemp_evt(overtemp_evt), .term_voltage_value(tv), .current_monitor_value(cm),
    .alert_in(alert_wire), .alert_out(alert_out), .alert_oe_n(alert_oe_n),
    .cpu_count(cpu_count), .cpu2_dual_domain(cpu2_dual_domain),
    .cpu3_dual_domain(cpu3_dual_domain), .cpu4_dual_domain(cpu4_dual_domain));

  amlr_host amlr_host_i (.alert_out(alert_out), .alert_oe_n(alert_oe_n), .alert_wire(alert_wire));

  // one strobe cycle per access, idle cycle between accesses
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask

  // read data lands on the edge after the strobe
  task automatic rd(input logic [7:0] a);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    v = reg_rdata;
  endtask

  task automatic settle();
    repeat (3) @(negedge mclk);
  endtask

  // alert level expected from the live sources under mask three
  function automatic logic exp_alert_n(input logic [3:0] s, input logic [7:0] m);
    return ~|(s & ~m[3:0]);
  endfunction

  // value left in each register after the setup pass
  function automatic logic [7:0] keep(input int i);
    return (i == 6) ? 8'h02 : (i < 2) ? 8'h00 : (i < 4) ? 8'h10 : 8'h80;
  endfunction

  task automatic print_verdict();
    if (n_errors == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // hang guard, well above the expected run length
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      print_verdict();
    end
  end

  initial begin
    v = $urandom(32'he59c6f1b);
    repeat (6) @(negedge mclk);
    rstn = 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd(addrs[i]);
      `CHK(v, rsts[i])
    end
    `CHK({cpu4_dual_domain, cpu3_dual_domain, cpu2_dual_domain, cpu_count}, 5'h00)
    `CHK(alert_oe_n, 1'b1)
    // random values read back as written
    for (int i = 0; i < 7; i++) begin
      m3 = 8'($urandom);
      wr(addrs[i], m3);
      rd(addrs[i]);
      `CHK(v, m3)
    end
    `CHK({cpu4_dual_domain, cpu3_dual_domain, cpu2_dual_domain, cpu_count}, m3[4:0])
    for (int i = 0; i < 7; i++) wr(addrs[i], keep(i));
    rd(8'h81);
    rd(8'h81);
    `CHK(cpu_count, 2'h2)
    // each live source against its mask bit
    for (int i = 0; i < 40; i++) begin
      m3 = 8'($urandom);
      src = 4'($urandom);
      if (i < 8) begin
        src = 4'h1 << (i % 4);
        m3 = (i < 4) ? {4'h0, src} : {4'hf, ~src};
      end
      wr(8'h82, m3);
      {overtemp_evt, link_err, data_err, client_ool[0]} = src;
      settle();
      `CHK(alert_oe_n, exp_alert_n(src, m3))
      `CHK(alert_wire, exp_alert_n(src, m3))
    end
    {overtemp_evt, link_err, data_err, client_ool} = 7'h00;
    wr(8'h82, 8'h00);
    tv = 8'h90;
    settle();
    `CHK(alert_oe_n, 1'b0)
    rd(8'h81);
    `CHK(v, 8'h80)
    rd(8'h81);
    `CHK(v, 8'h80)
    // individual mask alone leaves the summary path open
    wr(8'h83, 8'h80);
    settle();
    `CHK(alert_oe_n, 1'b0)
    wr(8'h82, 8'h80);
    settle();
    `CHK(alert_oe_n, 1'b1)
    tv = 8'h40;
    rd(8'h81);
    `CHK(v, 8'h80)
    rd(8'h81);
    `CHK(v, 8'h00)
    cm = 8'h05;
    wr(8'h83, 8'hc0);
    settle();
    `CHK(alert_oe_n, 1'b1)
    rd(8'h81);
    `CHK(v, 8'h40)
    cm = 8'h40;
    rd(8'h81);
    // client three not polled with three cpus configured
    client_ool = 4'he;
    wr(8'h83, 8'h38);
    settle();
    `CHK(alert_oe_n, 1'b1)
    rd(8'h81);
    `CHK(v, 8'h18)
    client_ool = 4'h0;
    rd(8'h81);
    rd(8'h81);
    `CHK(v, 8'h00)
    // lock freezes limits and config, masks stay writable
    lock = 1'b1;
    for (int i = 0; i < 7; i++) wr(addrs[i], 8'h5a);
    for (int i = 0; i < 7; i++) begin
      rd(addrs[i]);
      `CHK(v, (i < 2) ? 8'h5a : keep(i))
    end
    print_verdict();
  end
endmodule
